// ==== logic/urs_consts.svh ====
//
// Contract
// [RULE1] Register chosen by address and other bits
// [RULE2] Address 000: receive read, transmit write
// [RULE3] Address 010: ident read, FIFO control write
// [RULE4] Line and modem status are read-only
// [RULE5] Divisor bytes mapped only with access bit
// [RULE6] Sixteen-bit divisor, low 000, high 001
// [RULE7] Flow registers reachable only at key BF
// [RULE8] Threshold registers need enhanced and modem bit six
// [RULE9] FIFO ready needs selects low, loopback off
// [RULE10] Prescaler bit writable only with enhanced enable
// [RULE11] Enhanced control bits locked without enhanced enable
// [RULE12] Receive storage is 64-entry first-in first-out
// [RULE13] Shift register assembles serial receive characters
// [RULE14] Character format follows line format control
// [RULE15] FIFO off: entry zero, overwrite unread
// [RULE16] Full buffer drops characters, receiver never stalls
// [RULE17] Each entry carries its own error bits
// [RULE18] Status read never advances read pointer
// [RULE19] Line control bit seven enables divisor access
// [RULE20] FIFO ready bits 0,1,4,5, others zero
// [RULE21] Ident bits 7 and 6 show FIFO enable
`ifndef URS_CONSTS_SVH
`define URS_CONSTS_SVH

`define URS_ADDR_DATA   3'h0
`define URS_ADDR_IER    3'h1
`define URS_ADDR_IIR    3'h2
`define URS_ADDR_LCR    3'h3
`define URS_ADDR_MCR    3'h4
`define URS_ADDR_LSR    3'h5
`define URS_ADDR_MSR    3'h6
`define URS_ADDR_SPR    3'h7

`define URS_LCR_KEY     8'hBF
`define URS_LCR_DIVISOR_ACCESS_BIT    7
`define URS_LCR_PAR_EN  3
`define URS_LCR_EVEN    4
`define URS_LCR_FORCE   5
`define URS_EFR_ENH     4
`define URS_MCR_FRDY    2
`define URS_MCR_LOOP    4
`define URS_MCR_TCR     6
`define URS_FCR_FEN     0
`define URS_FCR_RXCLR   1
`define URS_FCR_TXCLR   2

`define URS_IER_ENH     8'hF0
`define URS_FCR_ENH     8'h30
`define URS_MCR_ENH     8'hE0
`define URS_FCR_SELFCLR 8'h06
`define URS_IIR_NOINT   4'h1

`define URS_RST_BYTE    8'h00
`define URS_RX_DEPTH    64
`define URS_RX_FULL     7'h40
`define URS_TX_DEPTH    16
`define URS_OVS_MID     4'h7
`define URS_OVS_LAST    4'hF

`endif

// ==== logic/urs_pkg.sv ====
package urs_pkg;

    typedef struct packed {
        logic       brk;
        logic       frame;
        logic       parity;
        logic [7:0] data;
    } urs_rx_entry_type;

    typedef struct packed {
        logic [2:0] addr;
        logic [7:0] data;
        logic       sel;
    } urs_wr_hold_type;

    typedef enum logic [4:0] {
        RX_IDLE   = 5'b00001,
        RX_START  = 5'b00010,
        RX_DATA   = 5'b00100,
        RX_PARITY = 5'b01000,
        RX_STOP   = 5'b10000
    } urs_rx_state_type;

endpackage

// ==== logic/urs_regsel.sv ====
`timescale 1ns/1ps
`include "urs_consts.svh"

// ****************************************************************
// Transmit buffer
// ****************************************************************
module urs_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 16
) (
    input  wire logic             clk_i,
    input  wire logic             rst_i,
    input  wire logic             flush_i,
    input  wire logic             in_valid_i,
    output logic                  in_ready_o,
    input  wire logic [WIDTH-1:0] in_data_i,
    output logic                  out_valid_o,
    input  wire logic             out_ready_i,
    output logic      [WIDTH-1:0] out_data_o
);
    localparam int AW = $clog2(DEPTH);
    localparam int CW = $clog2(DEPTH + 1);

    logic [WIDTH-1:0] mem_r [DEPTH];
    logic [AW-1:0]    wr_ptr_r;
    logic [AW-1:0]    rd_ptr_r;
    logic [CW-1:0]    count_r;
    wire              push = in_valid_i & in_ready_o;
    wire              pop  = out_valid_o & out_ready_i;

    assign in_ready_o  = count_r != CW'(DEPTH);
    assign out_valid_o = count_r != '0;
    assign out_data_o  = mem_r[rd_ptr_r];

    // Depth is a power of two, so pointers wrap by overflow
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            wr_ptr_r <= '0;
            rd_ptr_r <= '0;
            count_r  <= '0;
        end else if (flush_i) begin
            wr_ptr_r <= '0;
            rd_ptr_r <= '0;
            count_r  <= '0;
        end else begin
            wr_ptr_r <= AW'(wr_ptr_r + AW'(push));
            rd_ptr_r <= AW'(rd_ptr_r + AW'(pop));
            count_r  <= CW'(count_r + CW'(push) - CW'(pop));
        end
    end

    always_ff @(posedge clk_i) begin
        if (push) begin
            mem_r[wr_ptr_r] <= in_data_i;
        end
    end
endmodule // urs_fifo

// ****************************************************************
// Register select and receive path
// ****************************************************************
module urs_regsel (
    input  wire logic       clk_i,
    input  wire logic       rst_i,
    input  wire logic [2:0] addr_i,
    input  wire logic [7:0] data_i,
    output logic      [7:0] data_o,
    output logic            data_oe_o,
    input  wire logic       rd_n_i,
    input  wire logic       wr_n_i,
    input  wire logic       channel_a_select_n_i,
    input  wire logic       channel_b_select_n_i,
    input  wire logic       rx_i,
    input  wire logic [7:0] modem_pin_state_i,
    input  wire logic       peer_tx_ready_i,
    input  wire logic       peer_rx_ready_i,
    output logic            tx_valid_o,
    output logic      [7:0] tx_data_o,
    input  wire logic       tx_ready_i,
    output logic            tx_space_o,
    output logic     [15:0] divisor_o,
    output logic      [7:0] line_format_o,
    output logic      [7:0] modem_ctl_o
);
    function automatic logic hit(input logic [2:0] a, input logic [2:0] b);
        return a == b;
    endfunction

    function automatic logic [7:0] guard(input logic [7:0] old_v, input logic [7:0] new_v,
                                         input logic [7:0] mask, input logic en);
        return en ? new_v : ((old_v & mask) | (new_v & ~mask));
    endfunction

    // ************************************************************
    // Strobes
    // ************************************************************
    logic                     rd_q_r;
    logic                     wr_q_r;
    urs_pkg::urs_wr_hold_type hold_r;
    logic [7:0] ier_r, lcr_r, mcr_r, spr_r, dll_r, dlh_r, efr_r, fcr_r;
    logic [7:0] resume_char_one_r, resume_char_two_r, pause_char_one_r, pause_char_two_r, tcr_r, tlr_r;
    logic [7:0] rdata_r;

    wire sel       = ~channel_a_select_n_i;
    wire rd_pulse  = sel & ~rd_n_i & rd_q_r;
    wire wr_commit = hold_r.sel & wr_n_i & ~wr_q_r;
    wire divisor_access_bit      = lcr_r[`URS_LCR_DIVISOR_ACCESS_BIT];              // [RULE19]
    wire key       = lcr_r == `URS_LCR_KEY;             // [RULE7]
    wire enh       = efr_r[`URS_EFR_ENH];
    wire tcr_en    = enh & mcr_r[`URS_MCR_TCR];         // [RULE8]
    wire fifo_en   = fcr_r[`URS_FCR_FEN];
    wire frdy_en   = ~channel_a_select_n_i & ~channel_b_select_n_i
                   & mcr_r[`URS_MCR_FRDY] & ~mcr_r[`URS_MCR_LOOP]; // [RULE9]

    // Write address and data are captured every cycle while the strobe is low, then held once it rises
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            rd_q_r <= 1'b1;
            wr_q_r <= 1'b1;
            hold_r <= '0;
        end else begin
            rd_q_r <= rd_n_i;
            wr_q_r <= wr_n_i;
            if (~wr_n_i) begin
                hold_r <= '{addr: addr_i, data: data_i, sel: sel};
            end
        end
    end

    // ************************************************************
    // Write decode
    // ************************************************************
    wire [2:0] wa     = hold_r.addr;
    wire [7:0] wd     = hold_r.data;
    wire we_thr   = wr_commit & hit(wa, `URS_ADDR_DATA) & ~divisor_access_bit;  // [RULE2]
    wire we_dll   = wr_commit & hit(wa, `URS_ADDR_DATA) & divisor_access_bit;   // [RULE5] [RULE6]
    wire we_ier   = wr_commit & hit(wa, `URS_ADDR_IER) & ~divisor_access_bit;
    wire we_dlh   = wr_commit & hit(wa, `URS_ADDR_IER) & divisor_access_bit;    // [RULE5] [RULE6]
    wire we_fcr   = wr_commit & hit(wa, `URS_ADDR_IIR) & ~key;    // [RULE3]
    wire we_efr   = wr_commit & hit(wa, `URS_ADDR_IIR) & key;     // [RULE7]
    wire we_lcr   = wr_commit & hit(wa, `URS_ADDR_LCR);
    wire we_mcr   = wr_commit & hit(wa, `URS_ADDR_MCR) & ~key;
    wire we_resume_char_one  = wr_commit & hit(wa, `URS_ADDR_MCR) & key;
    wire we_resume_char_two  = wr_commit & hit(wa, `URS_ADDR_LSR) & key;     // [RULE4]
    wire we_pause_char_one = wr_commit & hit(wa, `URS_ADDR_MSR) & key;
    wire we_tcr   = wr_commit & hit(wa, `URS_ADDR_MSR) & ~key & tcr_en; // [RULE8]
    wire we_pause_char_two = wr_commit & hit(wa, `URS_ADDR_SPR) & key;
    wire we_tlr   = wr_commit & hit(wa, `URS_ADDR_SPR) & ~key & tcr_en;
    wire we_spr   = wr_commit & hit(wa, `URS_ADDR_SPR) & ~key & ~tcr_en;

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            {ier_r, lcr_r, mcr_r, spr_r} <= {4{`URS_RST_BYTE}};
            {dll_r, dlh_r, efr_r, fcr_r} <= {4{`URS_RST_BYTE}};
            {resume_char_one_r, resume_char_two_r, pause_char_one_r, pause_char_two_r, tcr_r, tlr_r} <= {6{`URS_RST_BYTE}};
        end else begin
            if (we_ier)   ier_r   <= guard(ier_r, wd, `URS_IER_ENH, enh);  // [RULE11]
            if (we_fcr)   fcr_r   <= guard(fcr_r, wd, `URS_FCR_ENH, enh) & ~`URS_FCR_SELFCLR; // [RULE11]
            if (we_mcr)   mcr_r   <= guard(mcr_r, wd, `URS_MCR_ENH, enh);  // [RULE10] [RULE11]
            if (we_lcr)   lcr_r   <= wd;
            if (we_dll)   dll_r   <= wd;
            if (we_dlh)   dlh_r   <= wd;
            if (we_efr)   efr_r   <= wd;
            if (we_resume_char_one)  resume_char_one_r  <= wd;
            if (we_resume_char_two)  resume_char_two_r  <= wd;
            if (we_pause_char_one) pause_char_one_r <= wd;
            if (we_pause_char_two) pause_char_two_r <= wd;
            if (we_tcr)   tcr_r   <= wd;
            if (we_tlr)   tlr_r   <= wd;
            if (we_spr)   spr_r   <= wd;
        end
    end

    assign divisor_o     = {dlh_r, dll_r};
    assign line_format_o = lcr_r;
    assign modem_ctl_o   = mcr_r;

    // ************************************************************
    // Transmit buffer
    // ************************************************************
    wire tx_flush = we_fcr & wd[`URS_FCR_TXCLR];

    urs_fifo #(.WIDTH(8), .DEPTH(`URS_TX_DEPTH)) u_tx_fifo (
        .clk_i       (clk_i),
        .rst_i       (rst_i),
        .flush_i     (tx_flush),
        .in_valid_i  (we_thr),
        .in_ready_o  (tx_space_o),
        .in_data_i   (wd),
        .out_valid_o (tx_valid_o),
        .out_ready_i (tx_ready_i),
        .out_data_o  (tx_data_o)
    );

    // ************************************************************
    // Receive shift register
    // ************************************************************
    urs_pkg::urs_rx_state_type rx_state_r, rx_state_nxt;
    logic [15:0] div_cnt_r;
    logic [3:0]  ovs_r, ovs_nxt;
    logic [2:0]  bit_r, bit_nxt;
    logic [7:0]  shift_r, shift_nxt;
    logic        perr_r, perr_nxt, pbit_r, pbit_nxt, rx_push;

    wire [15:0] div_last  = (divisor_o == 16'h0000) ? 16'h0000 : 16'(divisor_o - 16'h0001);
    wire        tick      = div_cnt_r >= div_last;
    wire        at_last   = tick & (ovs_r == `URS_OVS_LAST);
    wire [2:0]  wlen_last = 3'(3'h4 + {1'b0, lcr_r[1:0]});  // [RULE14]
    wire        exp_par   = lcr_r[`URS_LCR_FORCE] ? ~lcr_r[`URS_LCR_EVEN]
                          : (lcr_r[`URS_LCR_EVEN] ? ^shift_r : ~^shift_r); // [RULE14]
    wire urs_pkg::urs_rx_entry_type rx_entry = '{brk: ~rx_i & (shift_r == 8'h00) & ~pbit_r,
                                                 frame: ~rx_i, parity: perr_r, data: shift_r}; // [RULE17]

    always_comb begin
        rx_state_nxt = rx_state_r;
        ovs_nxt      = tick ? 4'(ovs_r + 4'h1) : ovs_r;
        bit_nxt      = bit_r;
        shift_nxt    = shift_r;
        perr_nxt     = perr_r;
        pbit_nxt     = pbit_r;
        rx_push      = 1'b0;
        case (rx_state_r)  // [RULE13]
            urs_pkg::RX_IDLE: begin
                ovs_nxt   = 4'h0;
                bit_nxt   = 3'h0;
                shift_nxt = 8'h00;
                perr_nxt  = 1'b0;
                pbit_nxt  = 1'b0;
                if (~rx_i) rx_state_nxt = urs_pkg::RX_START;
            end
            urs_pkg::RX_START: begin
                if (tick && ovs_r == `URS_OVS_MID) begin
                    ovs_nxt      = 4'h0;
                    rx_state_nxt = rx_i ? urs_pkg::RX_IDLE : urs_pkg::RX_DATA;
                end
            end
            urs_pkg::RX_DATA: begin
                if (at_last) begin
                    shift_nxt[bit_r] = rx_i;
                    bit_nxt          = 3'(bit_r + 3'h1);
                    if (bit_r == wlen_last) begin
                        rx_state_nxt = lcr_r[`URS_LCR_PAR_EN] ? urs_pkg::RX_PARITY : urs_pkg::RX_STOP;
                    end
                end
            end
            urs_pkg::RX_PARITY: begin
                if (at_last) begin
                    pbit_nxt     = rx_i;
                    perr_nxt     = rx_i != exp_par;
                    rx_state_nxt = urs_pkg::RX_STOP;
                end
            end
            urs_pkg::RX_STOP: begin
                if (at_last) begin
                    rx_push      = 1'b1;
                    rx_state_nxt = urs_pkg::RX_IDLE;
                end
            end
            default: rx_state_nxt = urs_pkg::RX_IDLE;
        endcase
    end

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            rx_state_r <= urs_pkg::RX_IDLE;
            div_cnt_r  <= 16'h0000;
            {ovs_r, bit_r, shift_r, perr_r, pbit_r} <= '0;
        end else begin
            rx_state_r <= rx_state_nxt;
            div_cnt_r  <= tick ? 16'h0000 : 16'(div_cnt_r + 16'h0001);
            {ovs_r, bit_r, shift_r, perr_r, pbit_r} <= {ovs_nxt, bit_nxt, shift_nxt, perr_nxt, pbit_nxt};
        end
    end

    // ************************************************************
    // Receive holding buffer
    // ************************************************************
    urs_pkg::urs_rx_entry_type rx_mem_r [`URS_RX_DEPTH];
    logic [5:0] rx_wr_ptr_r, rx_rd_ptr_r, rx_wr_ptr_nxt, rx_rd_ptr_nxt;
    logic [6:0] rx_count_r, rx_count_nxt;
    logic       overrun_r, err_any;

    wire rx_full  = rx_count_r == `URS_RX_FULL;
    wire rd_rhr   = rd_pulse & hit(addr_i, `URS_ADDR_DATA) & ~divisor_access_bit;   // [RULE2]
    wire rd_lsr   = rd_pulse & hit(addr_i, `URS_ADDR_LSR) & ~key;
    wire rx_pop   = rd_rhr & (rx_count_r != 7'h00);                   // [RULE18]
    wire rx_clr   = we_fcr & wd[`URS_FCR_RXCLR];
    wire rx_store = rx_push & (~fifo_en | ~rx_full);                  // [RULE16]
    wire ovr_set  = rx_push & (fifo_en ? rx_full : (rx_count_r != 7'h00) & ~rx_pop); // [RULE15] [RULE16]
    wire [5:0] rx_slot = fifo_en ? rx_wr_ptr_r : 6'h00;               // [RULE15]
    wire urs_pkg::urs_rx_entry_type head = rx_mem_r[rx_rd_ptr_r];

    always_comb begin
        if (rx_clr) begin
            rx_count_nxt = 7'h00;
        end else if (~fifo_en) begin
            // Leaving FIFO mode collapses the buffer to the single slot
            rx_count_nxt = rx_push ? 7'h01 : (rx_pop ? 7'h00 : {6'h00, rx_count_r != 7'h00});  // [RULE15]
        end else begin
            rx_count_nxt = 7'(rx_count_r + 7'(rx_store) - 7'(rx_pop));      // [RULE12]
        end
        rx_rd_ptr_nxt = (rx_clr | ~fifo_en) ? 6'h00 : 6'(rx_rd_ptr_r + 6'(rx_pop));
        rx_wr_ptr_nxt = (rx_clr | ~fifo_en) ? 6'h00 : 6'(rx_wr_ptr_r + 6'(rx_store));
    end

    // Error summary covers every held entry, not just the head
    always_comb begin
        err_any = 1'b0;
        for (int i = 0; i < `URS_RX_DEPTH; i++) begin
            if (7'(i) < rx_count_r) begin
                err_any = err_any | (|rx_mem_r[6'(rx_rd_ptr_r + 6'(i))][10:8]);
            end
        end
    end

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            rx_count_r  <= 7'h00;
            rx_rd_ptr_r <= 6'h00;
            rx_wr_ptr_r <= 6'h00;
            overrun_r   <= 1'b0;
        end else begin
            rx_count_r  <= rx_count_nxt;
            rx_rd_ptr_r <= rx_rd_ptr_nxt;
            rx_wr_ptr_r <= rx_wr_ptr_nxt;
            overrun_r   <= ovr_set | (overrun_r & ~rd_lsr);
        end
    end

    always_ff @(posedge clk_i) begin
        if (rx_store) rx_mem_r[rx_slot] <= rx_entry;  // [RULE12] [RULE17]
    end

    // ************************************************************
    // Read decode
    // ************************************************************
    wire [7:0] iir_v  = {fifo_en, fifo_en, 2'b00, `URS_IIR_NOINT};  // [RULE21]
    wire [7:0] lsr_v  = {err_any, ~tx_valid_o, ~tx_valid_o, head.brk, head.frame, head.parity,
                         overrun_r, rx_count_r != 7'h00};
    wire [7:0] frdy_v = {2'b00, peer_rx_ready_i, rx_count_r != 7'h00,
                         2'b00, peer_tx_ready_i, tx_space_o};         // [RULE20]
    logic [7:0] rd_mux;

    always_comb begin  // [RULE1]
        if (hit(addr_i, `URS_ADDR_DATA)) rd_mux = divisor_access_bit ? dll_r : head.data;
        else if (hit(addr_i, `URS_ADDR_IER)) rd_mux = divisor_access_bit ? dlh_r : ier_r;
        else if (hit(addr_i, `URS_ADDR_IIR)) rd_mux = key ? efr_r : iir_v;   // [RULE3]
        else if (hit(addr_i, `URS_ADDR_LCR)) rd_mux = lcr_r;
        else if (hit(addr_i, `URS_ADDR_MCR)) rd_mux = key ? resume_char_one_r : mcr_r;
        else if (hit(addr_i, `URS_ADDR_LSR)) rd_mux = key ? resume_char_two_r : lsr_v;  // [RULE4]
        else if (hit(addr_i, `URS_ADDR_MSR)) rd_mux = key ? pause_char_one_r : (tcr_en ? tcr_r : modem_pin_state_i);
        else if (key) rd_mux = pause_char_two_r;
        else if (tcr_en) rd_mux = tlr_r;
        else if (frdy_en) rd_mux = frdy_v;  // [RULE9]
        else rd_mux = spr_r;
    end

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) rdata_r <= 8'h00;
        else if (rd_pulse) rdata_r <= rd_mux;
    end

    assign data_o    = rdata_r;
    assign data_oe_o = sel & ~rd_n_i;

    // ************************************************************
    // Checks
    // ************************************************************
    rhr_pop_a: assert property (@(posedge clk_i) disable iff (rst_i) // [RULE2]
        rd_rhr && fifo_en && rx_count_r != 7'h00 && !rx_push && !rx_clr
        |=> rx_count_r == $past(rx_count_r) - 7'h01) else $error("receive read did not pop");
    lsr_nopop_a: assert property (@(posedge clk_i) disable iff (rst_i) // [RULE18]
        rd_lsr && !rx_push && !rx_clr |=> $stable(rx_count_r) && $stable(rx_rd_ptr_r))
        else $error("status read moved receive buffer");
    dll_write_a: assert property (@(posedge clk_i) disable iff (rst_i) // [RULE5]
        wr_commit && hit(wa, `URS_ADDR_DATA) && divisor_access_bit |=> dll_r == $past(wd) && !(tx_valid_o && !$past(tx_valid_o)))
        else $error("divisor low write wrong");
    efr_gate_a: assert property (@(posedge clk_i) disable iff (rst_i) // [RULE7]
        !key |=> $stable(efr_r) && $stable(resume_char_one_r) && $stable(pause_char_two_r)) else $error("flow register changed");
    mcr7_gate_a: assert property (@(posedge clk_i) disable iff (rst_i) // [RULE10]
        !enh |=> mcr_r[7:5] == $past(mcr_r[7:5]) && ier_r[7:4] == $past(ier_r[7:4]))
        else $error("enhanced bit changed while locked");
    tcr_gate_a: assert property (@(posedge clk_i) disable iff (rst_i) // [RULE8]
        !tcr_en |=> $stable(tcr_r) && $stable(tlr_r)) else $error("threshold register changed");
    iir_bits_a: assert property (@(posedge clk_i) disable iff (rst_i) // [RULE21]
        rd_pulse && hit(addr_i, `URS_ADDR_IIR) && !key |=> rdata_r[7:6] == {2{$past(fifo_en)}})
        else $error("ident fifo bits wrong");
    rx_drop_a: assert property (@(posedge clk_i) disable iff (rst_i) // [RULE16]
        rx_push && fifo_en && rx_full && !rx_pop && !rx_clr |=> rx_count_r == `URS_RX_FULL && overrun_r)
        else $error("full buffer not dropping");
    single_slot_a: assert property (@(posedge clk_i) disable iff (rst_i) // [RULE15]
        !fifo_en && $past(!fifo_en) |-> rx_count_r <= 7'h01) else $error("non-fifo mode holds more than one");
endmodule // urs_regsel

// ==== dv/urs_host_model.sv ====
`timescale 1ns/1ps

// ****************************************************************
// Host strobe bus master
// ****************************************************************
module urs_host_model (
    input  wire logic       clk_i,
    input  wire logic [7:0] rdata_i,
    output logic      [2:0] addr_o,
    output logic      [7:0] wdata_o,
    output logic            rd_n_o,
    output logic            wr_n_o,
    output logic            cs_n_o,
    output logic            done_o,
    output logic      [7:0] got_o
);
    initial begin
        addr_o  = 3'h0;
        wdata_o = 8'h00;
        rd_n_o  = 1'b1;
        wr_n_o  = 1'b1;
        cs_n_o  = 1'b1;
        done_o  = 1'b0;
        got_o   = 8'h00;
    end

    // Strobe low three cycles, then high two before the next one
    task automatic access(input logic wr, input logic [2:0] a, input logic [7:0] d);
        addr_o  <= a;
        wdata_o <= d;
        cs_n_o  <= 1'b0;
        rd_n_o  <= wr;
        wr_n_o  <= !wr;
        repeat (3) @(posedge clk_i);
        got_o   <= rdata_i;
        done_o  <= !wr;
        rd_n_o  <= 1'b1;
        wr_n_o  <= 1'b1;
        @(posedge clk_i);
        cs_n_o  <= 1'b1;
        done_o  <= 1'b0;
        // Released data bus shows the inverse, not the old byte
        wdata_o <= ~d;
        @(posedge clk_i);
    endtask
endmodule // urs_host_model

// ==== dv/urs_regsel_test.sv ====
`timescale 1ns/1ps

module urs_regsel_test;
    logic       clk_i = 1'b0;
    logic       rst_i = 1'b1;
    logic       rx_i = 1'b1;
    logic       tx_ready_i = 1'b0;
    logic       chan_b_sel_n = 1'b1;
    logic [7:0] msr_val = 8'h00;
    logic [7:0] rnd = 8'h60;
    logic [7:0] scr;
    logic [7:0] b1;
    logic [2:0] h_addr;
    logic [7:0] h_wdata;
    logic [7:0] h_got;
    logic [7:0] data_o;
    logic [7:0] tx_data_o;
    logic [7:0] modem_ctl_o;
    logic [7:0] line_format_o;
    logic [15:0] divisor_o;
    logic       h_rd_n;
    logic       h_wr_n;
    logic       h_cs_n;
    logic       h_done;
    logic       tx_valid_o;
    logic       tx_space_o;
    int         num_errors = 0;
    int         cmp_count = 0;
    logic [15:0] exp_q[$];

    always #5 clk_i = ~clk_i;

    urs_regsel u_urs_regsel (.clk_i(clk_i), .rst_i(rst_i), .addr_i(h_addr), .data_i(h_wdata),
        .data_o(data_o), .data_oe_o(), .rd_n_i(h_rd_n), .wr_n_i(h_wr_n),
        .channel_a_select_n_i(h_cs_n), .channel_b_select_n_i(chan_b_sel_n), .rx_i(rx_i),
        .modem_pin_state_i(msr_val), .peer_tx_ready_i(1'b1), .peer_rx_ready_i(1'b0),
        .tx_valid_o(tx_valid_o), .tx_data_o(tx_data_o), .tx_ready_i(tx_ready_i),
        .tx_space_o(tx_space_o), .divisor_o(divisor_o), .line_format_o(line_format_o),
        .modem_ctl_o(modem_ctl_o));

    urs_host_model u_urs_host_model (.clk_i(clk_i), .rdata_i(data_o), .addr_o(h_addr),
        .wdata_o(h_wdata), .rd_n_o(h_rd_n), .wr_n_o(h_wr_n), .cs_n_o(h_cs_n),
        .done_o(h_done), .got_o(h_got));

    function automatic logic [7:0] lfsr(input logic [7:0] s);
        return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
    endfunction

    task automatic chk(input logic [15:0] exp, input logic [15:0] got);
        cmp_count++;
        if (got !== exp) begin
            num_errors++;
            $display("wrong value t=%0t exp=%h got=%h", $time, exp, got);
        end
    endtask

    task automatic wr(input logic [2:0] a, input logic [7:0] d);
        u_urs_host_model.access(1'b1, a, d);
        @(posedge clk_i);
    endtask

    task automatic rd(input logic [2:0] a, input logic [7:0] exp);
        exp_q.push_back({8'h00, exp});
        u_urs_host_model.access(1'b0, a, 8'h00);
    endtask

    task automatic send_byte(input logic [7:0] b);
        logic [9:0] fr;
        fr = {1'b1, b, 1'b0};
        for (int i = 0; i < 10; i++) begin
            rx_i <= fr[i];
            repeat (16) @(posedge clk_i);
        end
    endtask

    task automatic stop_test();
        $display("comparisons %0d mismatches %0d", cmp_count, num_errors);
        if (num_errors == 0 && cmp_count > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask

    // ****************************************************************
    // Read result monitor
    // ****************************************************************
    always @(posedge clk_i) begin
        if (h_done === 1'b1)
            chk(exp_q.pop_front(), {8'h00, h_got});
    end

    initial begin
        #100000;
        num_errors++;
        stop_test();
    end

    // ****************************************************************
    // Scenarios
    // ****************************************************************
    initial begin
        repeat (5) @(posedge clk_i);
        rst_i <= 1'b0;
        @(posedge clk_i);
        rd(3'h3, 8'h00);
        rd(3'h5, 8'h60);
        rnd = lfsr(rnd);
        scr = rnd;
        wr(3'h7, scr);
        rd(3'h7, scr);
        $display("test reset_scratch done");
        wr(3'h3, 8'h80);
        rnd = lfsr(rnd);
        wr(3'h1, rnd);
        wr(3'h0, 8'h01);
        chk({rnd, 8'h01}, divisor_o);
        rd(3'h0, 8'h01);
        rd(3'h1, rnd);
        wr(3'h1, 8'h00);
        wr(3'h3, 8'h03);
        wr(3'h1, 8'h0F);
        chk(16'h0001, divisor_o);
        rd(3'h1, 8'h0F);
        chk(8'h03, line_format_o);
        wr(3'h2, 8'h01);
        rd(3'h2, 8'hC1);
        rnd = lfsr(rnd);
        msr_val <= rnd;
        wr(3'h5, 8'hFF);
        wr(3'h6, 8'hFF);
        rd(3'h6, rnd);
        rd(3'h5, 8'h60);
        $display("test divisor_status done");
        wr(3'h4, 8'hE4);
        chk(8'h04, modem_ctl_o);
        wr(3'h3, 8'hBF);
        wr(3'h2, 8'h10);
        wr(3'h4, 8'h5A);
        rd(3'h2, 8'h10);
        rd(3'h4, 8'h5A);
        wr(3'h3, 8'h03);
        rd(3'h4, 8'h04);
        wr(3'h4, 8'hE4);
        chk(8'hE4, modem_ctl_o);
        wr(3'h7, 8'h33);
        rd(3'h7, 8'h33);
        wr(3'h4, 8'h04);
        rd(3'h7, scr);
        chan_b_sel_n <= 1'b0;
        rd(3'h7, 8'h03);
        chan_b_sel_n <= 1'b1;
        $display("test enhanced_access done");
        for (int i = 0; i < 17; i++)
            wr(3'h0, 8'h10 + 8'(i));
        chk(16'h0000, tx_space_o);
        tx_ready_i <= 1'b1;
        for (int i = 0; i < 16; i++) begin
            @(posedge clk_i);
            chk(8'h10 + 8'(i), tx_data_o);
        end
        tx_ready_i <= 1'b0;
        @(posedge clk_i);
        chk(16'h0000, tx_valid_o);
        $display("test tx_fill done");
        rnd = lfsr(rnd);
        b1 = rnd;
        rnd = lfsr(rnd);
        send_byte(b1);
        send_byte(rnd);
        rd(3'h5, 8'h61);
        rd(3'h5, 8'h61);
        rd(3'h0, b1);
        rd(3'h0, rnd);
        rd(3'h5, 8'h60);
        $display("test rx_path done");
        // Single-slot mode: second character overwrites and flags overrun
        wr(3'h2, 8'h00);
        rd(3'h2, 8'h01);
        rnd = lfsr(rnd);
        b1 = rnd;
        rnd = lfsr(rnd);
        send_byte(b1);
        send_byte(rnd);
        rd(3'h5, 8'h63);
        rd(3'h0, rnd);
        rd(3'h5, 8'h60);
        $display("test rx_single done");
        repeat (4) @(posedge clk_i);
        chk(16'h0000, 16'(exp_q.size()));
        stop_test();
    end
endmodule // urs_regsel_test
